// ### cesf_regs.vh
`ifndef CESF_REGS_VH
`define CESF_REGS_VH
`define CESF_OFF_CTRL 12'h000
`define CESF_OFF_STATUS 12'h004
`define CESF_OFF_IRQ_STAT 12'h008
`define CESF_OFF_IRQ_MASK 12'h00C
`define CESF_OFF_RING_SIZE 12'h010
`define CESF_OFF_LAST_DW3 12'h014
`define CESF_OFF_TAIL 12'h018
`define CESF_OFF_POSTED 12'h01C
`define CESF_CTRL_EN_BIT 0
`define CESF_IRQ_POST_BIT 0
`define CESF_IRQ_WRAP_BIT 1
`define CESF_IRQ_FIX_BIT 2
`define CESF_RING_SIZE_RESET 16'h0010
`define CESF_SW_MSB 31
`define CESF_SW_LSB 17
`define CESF_NORETRY_BIT 31
`define CESF_EXTRA_BIT 30
`define CESF_CAT_MSB 27
`define CESF_CAT_LSB 25
`define CESF_DET_MSB 24
`define CESF_DET_LSB 17
`define CESF_TOGGLE_BIT 16
`define CESF_CAT_GENERIC 3'h0
`define CESF_CAT_CMD 3'h1
`define CESF_CAT_MEDIA 3'h2
`define CESF_CAT_VENDOR 3'h7
`define CESF_DET_VENDOR_BASE 8'hC0
`endif

// ### cesf_status_pick.v
`timescale 1ns/1ps
`default_nettype none
module cesf_status_pick #(
  parameter N = 4
) (
  input wire [N-1:0] cand_valid,
  input wire [8*N-1:0] cand_code,
  output reg [7:0] best_code,
  output reg any_valid
);
  integer i;
  // Lowest valued applicable code wins
  always @* begin
    best_code = 8'hFF;
    any_valid = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (cand_valid[i] && (!any_valid || cand_code[8*i +: 8] < best_code)) begin
        best_code = cand_code[8*i +: 8];
        any_valid = 1'b1;
      end
    end
    if (!any_valid) begin
      best_code = 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### cesf_word_pack.v
`timescale 1ns/1ps
`default_nettype none
`include "cesf_regs.vh"
module cesf_word_pack (
  input wire [2:0] category,
  input wire [7:0] detail,
  input wire extra_info,
  input wire no_retry,
  input wire toggle,
  input wire [15:0] tag,
  output wire [31:0] dw3,
  output wire [14:0] status_word
);
  // Reserved 29:28 forced to zero
  assign status_word = {no_retry, extra_info, 2'b00, category, detail};
  assign dw3 = {status_word, toggle, tag};
endmodule
`default_nettype wire

// ### cesf_formatter.v
`timescale 1ns/1ps
`default_nettype none
`include "cesf_regs.vh"
module cesf_formatter #(
  parameter TAIL_W = 16,
  parameter NCAND = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cmpl_valid,
  output wire cmpl_ready,
  input wire [15:0] request_tag,
  input wire [15:0] source_queue_number,
  input wire [15:0] source_queue_consume_index,
  input wire [31:0] cmd_specific_dw,
  input wire [2:0] status_category,
  input wire [NCAND-1:0] cand_valid,
  input wire [8*NCAND-1:0] cand_code,
  input wire media_error,
  input wire retry_hopeless,
  input wire recovery_abort,
  input wire log_has_more,
  output reg entry_valid,
  output reg [TAIL_W-1:0] entry_slot,
  output reg [127:0] entry_data,
  output wire irq
);
  // ****************************************
  // Register file
  // ****************************************
  reg ctrl_en;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [TAIL_W-1:0] ring_size;
  reg [31:0] last_dw3;
  reg [TAIL_W-1:0] tail;
  reg [31:0] posted;
  reg toggle;
  reg [31:0] next_prdata;
  wire wr = psel && penable && pwrite;
  // Rise taken from the enabling write itself, so no post can slip in before the re-arm
  wire en_rise = wr && (paddr == `CESF_OFF_CTRL) && pwdata[`CESF_CTRL_EN_BIT] && !ctrl_en;
  wire rd_hit;
  wire post = cmpl_valid && ctrl_en;
  wire wrap = post && (tail == ring_size - 1'b1);
  wire [2:0] ev;
  reg [2:0] category_fix;
  reg [7:0] detail_fix;
  reg fixed;
  wire [7:0] best_code;
  wire any_code;
  wire [31:0] dw3;
  wire [14:0] status_word;
  wire no_retry;
  wire extra_info;
  assign pready = 1'b1;
  assign rd_hit = (paddr == `CESF_OFF_CTRL) || (paddr == `CESF_OFF_STATUS) ||
    (paddr == `CESF_OFF_IRQ_STAT) || (paddr == `CESF_OFF_IRQ_MASK) ||
    (paddr == `CESF_OFF_RING_SIZE) || (paddr == `CESF_OFF_LAST_DW3) ||
    (paddr == `CESF_OFF_TAIL) || (paddr == `CESF_OFF_POSTED);
  assign pslverr = psel && penable && !rd_hit;
  // Accept whenever enabled; disabled ring drops nothing since ready is low
  assign cmpl_ready = ctrl_en;
  assign ev = {fixed & post, wrap, post};
  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Status selection
  // ****************************************
  cesf_status_pick #(
    .N(NCAND)
  ) u_pick (
    .cand_valid(cand_valid),
    .cand_code(cand_code),
    .best_code(best_code),
    .any_valid(any_code)
  );

  // Category forced by error kind; reserved types mapped to vendor
  always @* begin
    fixed = 1'b0;
    category_fix = status_category;
    if (media_error) begin
      category_fix = `CESF_CAT_MEDIA;
    end else if (status_category > `CESF_CAT_MEDIA && status_category != `CESF_CAT_VENDOR) begin
      category_fix = `CESF_CAT_VENDOR;
      fixed = 1'b1;
    end
    // Command specific failures arrive as category 1 and pass unchanged
    detail_fix = any_code ? best_code : 8'h00;
    if (category_fix == `CESF_CAT_VENDOR && detail_fix < `CESF_DET_VENDOR_BASE && any_code) begin
      detail_fix = `CESF_DET_VENDOR_BASE;
    end
  end
  assign no_retry = retry_hopeless && !recovery_abort;
  assign extra_info = log_has_more && any_code;

  cesf_word_pack u_pack (
    .category(category_fix),
    .detail(detail_fix),
    .extra_info(extra_info),
    .no_retry(no_retry),
    .toggle(toggle),
    .tag(request_tag),
    .dw3(dw3),
    .status_word(status_word)
  );

  // ****************************************
  // Ring tail and toggle
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tail <= {TAIL_W{1'b0}};
      toggle <= 1'b1;
      posted <= 32'h0000_0000;
    end else begin
      // Enable rise and post never coincide: post needs the enable already set
      if (en_rise) begin
        toggle <= 1'b1;
        tail <= {TAIL_W{1'b0}};
      end else if (post) begin
        posted <= posted + 32'h0000_0001;
        if (wrap) begin
          tail <= {TAIL_W{1'b0}};
          toggle <= ~toggle;
        end else begin
          tail <= tail + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Entry output
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_valid <= 1'b0;
      entry_slot <= {TAIL_W{1'b0}};
      entry_data <= 128'h0;
      last_dw3 <= 32'h0000_0000;
    end else begin
      entry_valid <= post;
      if (post) begin
        entry_slot <= tail;
        // Reserved second doubleword stays zero
        entry_data <= {dw3, source_queue_number, source_queue_consume_index, 32'h0000_0000,
          cmd_specific_dw};
        last_dw3 <= dw3;
      end
    end
  end

  // ****************************************
  // APB access
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      irq_mask <= 3'h0;
      irq_stat <= 3'h0;
      ring_size <= `CESF_RING_SIZE_RESET;
    end else begin
      // Set wins over write-one clear
      if (wr && paddr == `CESF_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr) begin
        if (paddr == `CESF_OFF_CTRL) begin
          ctrl_en <= pwdata[`CESF_CTRL_EN_BIT];
        end else if (paddr == `CESF_OFF_IRQ_MASK) begin
          irq_mask <= pwdata[2:0];
        end else if (paddr == `CESF_OFF_RING_SIZE) begin
          // Zero size would only wrap after 65536 entries; held at one minimum
          ring_size <= (pwdata[TAIL_W-1:0] == {TAIL_W{1'b0}}) ? {{(TAIL_W-1){1'b0}}, 1'b1} :
            pwdata[TAIL_W-1:0];
        end
      end
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    if (paddr == `CESF_OFF_CTRL) begin
      next_prdata = {31'h0, ctrl_en};
    end else if (paddr == `CESF_OFF_STATUS) begin
      next_prdata = {30'h0, toggle, ctrl_en};
    end else if (paddr == `CESF_OFF_IRQ_STAT) begin
      next_prdata = {29'h0, irq_stat};
    end else if (paddr == `CESF_OFF_IRQ_MASK) begin
      next_prdata = {29'h0, irq_mask};
    end else if (paddr == `CESF_OFF_RING_SIZE) begin
      next_prdata = {{(32-TAIL_W){1'b0}}, ring_size};
    end else if (paddr == `CESF_OFF_LAST_DW3) begin
      next_prdata = last_dw3;
    end else if (paddr == `CESF_OFF_TAIL) begin
      next_prdata = {{(32-TAIL_W){1'b0}}, tail};
    end else if (paddr == `CESF_OFF_POSTED) begin
      next_prdata = posted;
    end
  end

  // Read data latched in setup so the access phase sees a steady flop output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// ### cesf_formatter_props.sv
`timescale 1ns/1ps
`default_nettype none
module cesf_formatter_props #(
  parameter NCAND = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmpl_valid,
  input wire logic cmpl_ready,
  input wire logic [15:0] request_tag,
  input wire logic [15:0] source_queue_number,
  input wire logic [NCAND-1:0] cand_valid,
  input wire logic media_error,
  input wire logic retry_hopeless,
  input wire logic recovery_abort,
  input wire logic log_has_more,
  input wire logic entry_valid,
  input wire logic [127:0] entry_data
);
  // ****
  // Entry checks
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = cmpl_valid && cmpl_ready;
  tag_copy_a: assert property (acc |=> entry_valid && entry_data[111:96] == $past(request_tag))
    else $error("tag lost");
  queue_num_a: assert property (acc |=> entry_data[95:80] == $past(source_queue_number))
    else $error("queue number lost");
  resv_bits_a: assert property (entry_valid |-> entry_data[125:124] == 2'b00)
    else $error("reserved bits set");
  dw1_zero_a: assert property (entry_valid |-> entry_data[63:32] == 32'h0)
    else $error("second word not zero");
  cat_legal_a: assert property (entry_valid |-> !(entry_data[123:121] inside {[3'h3:3'h6]}))
    else $error("reserved category");
  media_cat_a: assert property (acc && media_error |=> entry_data[123:121] == 3'h2)
    else $error("media category");
  no_retry_a: assert property (acc |=> entry_data[127] == $past(retry_hopeless && !recovery_abort))
    else $error("no retry flag");
  extra_info_a: assert property (acc |=> entry_data[126] == $past(log_has_more && |cand_valid))
    else $error("extra info flag");
endmodule
bind cesf_formatter cesf_formatter_props #(.NCAND(NCAND)) u_props (.pclk, .presetn, .cmpl_valid, .cmpl_ready,
  .request_tag, .source_queue_number, .cand_valid, .media_error, .retry_hopeless, .recovery_abort,
  .log_has_more, .entry_valid, .entry_data);
`default_nettype wire

// ### cesf_host_ring.sv
`timescale 1ns/1ps
`default_nettype none
module cesf_host_ring (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic entry_valid,
  input wire logic [15:0] entry_slot,
  input wire logic [127:0] entry_data,
  output logic [15:0] n_new
);
  // ****
  // Host view of the ring
  // ****
  logic seen [16];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) seen[i] <= 1'b0;
      n_new <= 16'h0000;
    end else if (entry_valid) begin
      // A slot only counts as new when its toggle differs from what the host last saw
      if (entry_data[112] !== seen[entry_slot[3:0]]) n_new <= n_new + 16'h0001;
      seen[entry_slot[3:0]] <= entry_data[112];
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****
  // Bench
  // ****
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, cmpl_valid = '0, media_error = '0;
  logic retry_hopeless = '0, recovery_abort = '0, log_has_more = '0, pready, pslverr, cmpl_ready, entry_valid, irq, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, cmd_specific_dw = '0, cand_code = 32'h9005C381, rd;
  logic [15:0] request_tag = '0, source_queue_number = '0, source_queue_consume_index = '0, entry_slot, n_new;
  logic [2:0] status_category = '0;
  logic [3:0] cand_valid = '0;
  logic [127:0] entry_data;
  int errors = 0, n_checks = 0;
  always #50 pclk = ~pclk;
  cesf_formatter dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmpl_valid, .cmpl_ready, .request_tag, .source_queue_number, .source_queue_consume_index, .cmd_specific_dw,
    .status_category, .cand_valid, .cand_code, .media_error, .retry_hopeless, .recovery_abort, .log_has_more,
    .entry_valid, .entry_slot, .entry_data, .irq);
  cesf_host_ring host (.pclk, .presetn, .entry_valid, .entry_slot, .entry_data, .n_new);
  task chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (pready !== 1'b1) begin
      errors++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    // Idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task post(input int i, input logic [2:0] c, input logic tg);
    logic [15:0] t;
    logic [3:0] f, cv;
    logic [7:0] d;
    logic [2:0] k;
    logic [127:0] e;
    t = 16'hA000 + 16'(i);
    f = 4'(i);
    cv = 4'(i * 5);
    d = cv == 4'h0 ? 8'h00 : 8'hFF;
    for (int j = 0; j < 4; j++) if (cv[j] && cand_code[8*j+:8] < d) d = cand_code[8*j+:8];
    k = f[3] ? 3'h2 : (c > 3'h2 && c < 3'h7) ? 3'h7 : c;
    if (k == 3'h7 && cv != 4'h0 && d < 8'hC0) d = 8'hC0;
    e = {f[2] & ~f[1], f[0] & (|cv), 2'b00, k, d, tg, t, ~t, t + 16'h1, 32'h0, t, ~t};
    {request_tag, source_queue_number, source_queue_consume_index, cmd_specific_dw} <= {t, ~t, t + 16'h1, t, ~t};
    {status_category, media_error, retry_hopeless, recovery_abort, log_has_more, cand_valid, cmpl_valid} <= {c, f, cv, 1'b1};
    @(posedge pclk);
    chk(cmpl_ready, 1'b1);
    cmpl_valid <= 1'b0;
    @(posedge pclk);
    chk({entry_valid, entry_slot}, {1'b1, 16'(i % 4)});
    chk(entry_data, e);
  endtask
  task t_regs;
    chk(cmpl_ready, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 12'h020, 32'h0);
    chk({er, rd}, 33'h100000000);
    apb(1'b1, 12'h010, 32'h4);
    $display("register test done");
  endtask
  task t_ring;
    logic [2:0] cats [9];
    cats = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h5, 3'h0, 3'h1, 3'h3, 3'h6};
    apb(1'b1, 12'h00C, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge pclk);
    for (int i = 0; i < 9; i++) post(i, cats[i], ((i / 4) % 2) == 0);
    @(posedge pclk);
    chk(n_new, 16'h9);
    chk(irq, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h9);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0521A008);
    apb(1'b1, 12'h008, 32'h7);
    chk(irq, 1'b0);
    $display("ring test done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_ring;
    final_report;
  end
endmodule
`default_nettype wire
